//--- core/sdm_pkg.sv
// Purpose: shared constants and carriers for the shared-pin function mux
// Assumes: one 100 MHz clock, asynchronous active-low reset
// Notes: pin index 0 is the port E slave-select pad, 1 and 2 the phase pads
package sdm_pkg;
	localparam int SDM_NPIN = 3;
	localparam int SDM_PIN_SS = 0;
	localparam int SDM_PIN_PHA = 1;
	localparam int SDM_PIN_PHB = 2;
	localparam int SDM_PE_PU_BIT = 7;
	localparam int SDM_PC_PU_PHA_BIT = 0;
	localparam int SDM_PC_PU_PHB_BIT = 1;
	localparam logic [7:0] SDM_PE_PU_RST = 8'hFF;
	localparam logic [7:0] SDM_PC_PU_RST = 8'hFF;
	localparam logic [2:0] SDM_GPIO_RST = 3'h0;

	typedef enum logic [1:0] {
		SDM_FN_PERIPH = 2'b00,
		SDM_FN_TIMER = 2'b01,
		SDM_FN_SPI = 2'b10,
		SDM_FN_GPIO = 2'b11
	} sdm_fn_e;

	// pad-facing view of one pin
	typedef struct packed {
		logic out;
		logic oe_n;
		logic pu_en;
	} sdm_pad_s;

	// peripheral drive of one pin
	typedef struct packed {
		logic out;
		logic oe;
	} sdm_drv_s;
endpackage

//--- core/sdm_fn_sel.sv
// Purpose: selects the active function of one phase pad
// Assumes: select inputs are registered upstream
// Notes: priority is gpio, then spi alternate, then timer, then decoder
`timescale 1ns/1ps
module sdm_fn_sel (
	input wire logic i_variant_full,
	input wire logic i_sw_cfg,
	input wire logic i_gpio_sel,
	input wire logic i_alt_sel,
	input wire logic i_timer_sel,
	output sdm_pkg::sdm_fn_e o_fn,
	output logic o_unrouted
);
	import sdm_pkg::*;
	wire logic pick_gpio = i_gpio_sel;
	wire logic pick_spi = !i_gpio_sel && i_alt_sel;
	wire logic pick_tmr = !i_gpio_sel && !i_alt_sel && i_timer_sel;
	// reduced variant has no default until software configures
	assign o_unrouted = !i_variant_full && !i_sw_cfg;
	assign o_fn = pick_gpio ? SDM_FN_GPIO :
		pick_spi ? SDM_FN_SPI :
		pick_tmr ? SDM_FN_TIMER : SDM_FN_PERIPH;
endmodule

//--- core/sdm_pad_drv.sv
// Purpose: forms pad output, active-low enable and pull-up for one pin
// Assumes: function code already resolved
// Notes: gpio direction bit high means output
`timescale 1ns/1ps
module sdm_pad_drv (
	input sdm_pkg::sdm_fn_e i_fn,
	input wire logic i_unrouted,
	input wire logic i_pu_bit,
	input wire logic i_gpio_dir,
	input wire logic i_gpio_out,
	input sdm_pkg::sdm_drv_s i_tmr,
	input sdm_pkg::sdm_drv_s i_spi,
	output sdm_pkg::sdm_pad_s o_pad
);
	import sdm_pkg::*;
	wire logic drv_gpio = (i_fn == SDM_FN_GPIO) && i_gpio_dir;
	wire logic drv_tmr = (i_fn == SDM_FN_TIMER) && i_tmr.oe;
	wire logic drv_spi = (i_fn == SDM_FN_SPI) && i_spi.oe;
	wire logic drives = !i_unrouted && (drv_gpio || drv_tmr || drv_spi);
	assign o_pad.out = drv_gpio ? i_gpio_out :
		drv_tmr ? i_tmr.out : drv_spi ? i_spi.out : 1'b0;
	assign o_pad.oe_n = !drives;
	// pull-up off while driving or when software clears its bit
	assign o_pad.pu_en = i_pu_bit && !drives;
endmodule

//--- core/sdm_pin_mux.sv
// Purpose: function mux for slave-select pad and two decoder phase pads
// Assumes: all inputs synchronous to i_sys_clk
// Notes: every output is registered; i_ce low freezes all state
//
// Summary of operation
// - slave-select pad defaults to spi0 function
// - slave-select input feeds spi0 in slave mode
// - gpio function per-pin input or output
// - port e bit 7 clear disables pull-up
// - phase a alternate routes spi1 clock
// - phase b alternate routes spi1 data
// - full variant defaults phase a decoder
// - full variant defaults phase b decoder
// - port c bit 0 clear disables pull-up
// - port c bit 1 clear disables pull-up
// - spi1 clock out in master, in slave
// - spi1 data half-cycle before latching edge
`timescale 1ns/1ps
module sdm_pin_mux (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_variant_full,
	input wire logic [7:0] i_port_e_pullup_enable,
	input wire logic [7:0] i_port_c_pullup_enable,
	input wire logic i_phase_a_alternate_select,
	input wire logic i_phase_b_alternate_select,
	input wire logic [2:0] i_gpio_sel,
	input wire logic [2:0] i_gpio_dir,
	input wire logic [2:0] i_gpio_out,
	input wire logic [1:0] i_timer_sel,
	input wire logic i_sw_cfg_done,
	input wire logic i_spi1_master,
	input wire logic i_spi1_serial_clock_out,
	input wire logic i_spi1_master_out_slave_in_out,
	input sdm_pkg::sdm_drv_s i_timer_b_channel_zero,
	input sdm_pkg::sdm_drv_s i_timer_b_channel_one,
	input wire logic [2:0] i_pad_in,
	output sdm_pkg::sdm_pad_s [2:0] o_pad,
	output logic o_spi0_slave_select,
	output logic o_decoder1_phase_a_input,
	output logic o_decoder1_phase_b_input,
	output logic o_spi1_serial_clock_in,
	output logic o_spi1_master_out_slave_in_in,
	output logic o_timer_b_channel_zero_in,
	output logic o_timer_b_channel_one_in,
	output logic [2:0] o_gpio_in,
	output logic [1:0] o_unrouted
);
	import sdm_pkg::*;

	sdm_fn_e fn_a;
	sdm_fn_e fn_b;
	logic unr_a;
	logic unr_b;
	logic sw_cfg;
	sdm_pad_s [2:0] next_pad;
	sdm_drv_s spi_a;
	sdm_drv_s spi_b;
	sdm_drv_s none_drv;

	// software configuration is latched once seen, cleared by reset only
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sw_cfg <= 1'b0;
		end else if (i_ce && i_sw_cfg_done) begin
			sw_cfg <= 1'b1;
		end
	end

	sdm_fn_sel u_sel_a (
		.i_variant_full(i_variant_full),
		.i_sw_cfg(sw_cfg),
		.i_gpio_sel(i_gpio_sel[SDM_PIN_PHA]),
		.i_alt_sel(i_phase_a_alternate_select),
		.i_timer_sel(i_timer_sel[0]),
		.o_fn(fn_a),
		.o_unrouted(unr_a)
	);

	sdm_fn_sel u_sel_b (
		.i_variant_full(i_variant_full),
		.i_sw_cfg(sw_cfg),
		.i_gpio_sel(i_gpio_sel[SDM_PIN_PHB]),
		.i_alt_sel(i_phase_b_alternate_select),
		.i_timer_sel(i_timer_sel[1]),
		.o_fn(fn_b),
		.o_unrouted(unr_b)
	);

	// spi1 clock drives pad only as master, data likewise
	assign spi_a.out = i_spi1_serial_clock_out;
	assign spi_a.oe = i_spi1_master;
	// master presents data ahead of the latching edge
	assign spi_b.out = i_spi1_master_out_slave_in_out;
	assign spi_b.oe = i_spi1_master;
	assign none_drv = '0;

	// slave-select pad: spi0 input unless gpio selected
	sdm_pad_drv u_drv_ss (
		.i_fn(i_gpio_sel[SDM_PIN_SS] ? SDM_FN_GPIO : SDM_FN_PERIPH),
		.i_unrouted(1'b0),
		.i_pu_bit(i_port_e_pullup_enable[SDM_PE_PU_BIT]),
		.i_gpio_dir(i_gpio_dir[SDM_PIN_SS]),
		.i_gpio_out(i_gpio_out[SDM_PIN_SS]),
		.i_tmr(none_drv),
		.i_spi(none_drv),
		.o_pad(next_pad[SDM_PIN_SS])
	);

	sdm_pad_drv u_drv_a (
		.i_fn(fn_a),
		.i_unrouted(unr_a),
		.i_pu_bit(i_port_c_pullup_enable[SDM_PC_PU_PHA_BIT]),
		.i_gpio_dir(i_gpio_dir[SDM_PIN_PHA]),
		.i_gpio_out(i_gpio_out[SDM_PIN_PHA]),
		.i_tmr(i_timer_b_channel_zero),
		.i_spi(spi_a),
		.o_pad(next_pad[SDM_PIN_PHA])
	);

	sdm_pad_drv u_drv_b (
		.i_fn(fn_b),
		.i_unrouted(unr_b),
		.i_pu_bit(i_port_c_pullup_enable[SDM_PC_PU_PHB_BIT]),
		.i_gpio_dir(i_gpio_dir[SDM_PIN_PHB]),
		.i_gpio_out(i_gpio_out[SDM_PIN_PHB]),
		.i_tmr(i_timer_b_channel_one),
		.i_spi(spi_b),
		.o_pad(next_pad[SDM_PIN_PHB])
	);

	// inbound routing, idle-high for unselected slave-select and decoder inputs, idle-low for spi1, timer and gpio inputs
	wire logic ss_periph = !i_gpio_sel[SDM_PIN_SS];
	wire logic next_ss = ss_periph ? i_pad_in[SDM_PIN_SS] : 1'b1;
	wire logic a_ok = !unr_a;
	wire logic b_ok = !unr_b;
	wire logic next_pha = (a_ok && fn_a == SDM_FN_PERIPH) ?
		i_pad_in[SDM_PIN_PHA] : 1'b1;
	wire logic next_phb = (b_ok && fn_b == SDM_FN_PERIPH) ?
		i_pad_in[SDM_PIN_PHB] : 1'b1;
	wire logic next_sclk = (a_ok && fn_a == SDM_FN_SPI && !i_spi1_master) ?
		i_pad_in[SDM_PIN_PHA] : 1'b0;
	wire logic next_mosi = (b_ok && fn_b == SDM_FN_SPI && !i_spi1_master) ?
		i_pad_in[SDM_PIN_PHB] : 1'b0;
	wire logic next_tb0 = (a_ok && fn_a == SDM_FN_TIMER) ?
		i_pad_in[SDM_PIN_PHA] : 1'b0;
	wire logic next_tb1 = (b_ok && fn_b == SDM_FN_TIMER) ?
		i_pad_in[SDM_PIN_PHB] : 1'b0;
	logic [2:0] next_gpio_in;
	assign next_gpio_in[SDM_PIN_SS] = i_gpio_sel[SDM_PIN_SS] &&
		i_pad_in[SDM_PIN_SS];
	assign next_gpio_in[SDM_PIN_PHA] = a_ok && fn_a == SDM_FN_GPIO &&
		i_pad_in[SDM_PIN_PHA];
	assign next_gpio_in[SDM_PIN_PHB] = b_ok && fn_b == SDM_FN_GPIO &&
		i_pad_in[SDM_PIN_PHB];

	// pad-side registers per pin; reset leaves pads undriven, pull-ups on
	genvar gi;
	generate
		for (gi = 0; gi < SDM_NPIN; gi++) begin : g_pad
			always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					o_pad[gi] <= '{out: 1'b0, oe_n: 1'b1, pu_en: 1'b1};
				end else if (i_ce) begin
					o_pad[gi] <= next_pad[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_spi0_slave_select <= 1'b1;
			o_decoder1_phase_a_input <= 1'b1;
			o_decoder1_phase_b_input <= 1'b1;
			o_spi1_serial_clock_in <= 1'b0;
			o_spi1_master_out_slave_in_in <= 1'b0;
			o_timer_b_channel_zero_in <= 1'b0;
			o_timer_b_channel_one_in <= 1'b0;
			o_gpio_in <= SDM_GPIO_RST;
			o_unrouted <= 2'h0;
		end else if (i_ce) begin
			o_spi0_slave_select <= next_ss;
			o_decoder1_phase_a_input <= next_pha;
			o_decoder1_phase_b_input <= next_phb;
			o_spi1_serial_clock_in <= next_sclk;
			o_spi1_master_out_slave_in_in <= next_mosi;
			o_timer_b_channel_zero_in <= next_tb0;
			o_timer_b_channel_one_in <= next_tb1;
			o_gpio_in <= next_gpio_in;
			o_unrouted <= {unr_b, unr_a};
		end
	end

	property p_ss_route;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !i_gpio_sel[SDM_PIN_SS] |=>
			o_spi0_slave_select == $past(i_pad_in[SDM_PIN_SS]);
	endproperty
	a_ss_route: assert property (p_ss_route)
		else $error("slave select not routed to spi0");

	property p_ss_pu;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce &&
			!i_port_e_pullup_enable[SDM_PE_PU_BIT] |=>
			!o_pad[SDM_PIN_SS].pu_en;
	endproperty
	a_ss_pu: assert property (p_ss_pu)
		else $error("port e pull-up not disabled");

	property p_pha_pu;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce &&
			!i_port_c_pullup_enable[SDM_PC_PU_PHA_BIT] |=>
			!o_pad[SDM_PIN_PHA].pu_en;
	endproperty
	a_pha_pu: assert property (p_pha_pu)
		else $error("phase a pull-up not disabled");

	property p_phb_pu;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce &&
			!i_port_c_pullup_enable[SDM_PC_PU_PHB_BIT] |=>
			!o_pad[SDM_PIN_PHB].pu_en;
	endproperty
	a_phb_pu: assert property (p_phb_pu)
		else $error("phase b pull-up not disabled");

	property p_sclk_master;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !unr_a && !i_gpio_sel[SDM_PIN_PHA] &&
			i_phase_a_alternate_select && i_spi1_master |=>
			!o_pad[SDM_PIN_PHA].oe_n &&
			o_pad[SDM_PIN_PHA].out == $past(i_spi1_serial_clock_out);
	endproperty
	a_sclk_master: assert property (p_sclk_master)
		else $error("spi1 clock not driven in master mode");

	property p_mosi_slave;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !unr_b && !i_gpio_sel[SDM_PIN_PHB] &&
			i_phase_b_alternate_select && !i_spi1_master |=>
			o_pad[SDM_PIN_PHB].oe_n &&
			o_spi1_master_out_slave_in_in == $past(i_pad_in[SDM_PIN_PHB]);
	endproperty
	a_mosi_slave: assert property (p_mosi_slave)
		else $error("spi1 data not received in slave mode");

	property p_pha_default;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && i_variant_full && i_gpio_sel == 3'h0 &&
			!i_phase_a_alternate_select && i_timer_sel == 2'h0 |=>
			o_decoder1_phase_a_input == $past(i_pad_in[SDM_PIN_PHA]);
	endproperty
	a_pha_default: assert property (p_pha_default)
		else $error("phase a default not decoder");

	property p_phb_default;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && i_variant_full && i_gpio_sel == 3'h0 &&
			!i_phase_b_alternate_select && i_timer_sel == 2'h0 |=>
			o_decoder1_phase_b_input == $past(i_pad_in[SDM_PIN_PHB]);
	endproperty
	a_phb_default: assert property (p_phb_default)
		else $error("phase b default not decoder");

	property p_gpio_dir;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && i_gpio_sel[SDM_PIN_SS] |=>
			o_pad[SDM_PIN_SS].oe_n == !$past(i_gpio_dir[SDM_PIN_SS]);
	endproperty
	a_gpio_dir: assert property (p_gpio_dir)
		else $error("gpio direction not honoured");

	property p_ss_default;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !i_gpio_sel[SDM_PIN_SS] |=>
			o_pad[SDM_PIN_SS].oe_n;
	endproperty
	a_ss_default: assert property (p_ss_default)
		else $error("slave select pad driven outside gpio");

	property p_unrouted;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !i_variant_full && !sw_cfg |=>
			o_unrouted == 2'h3 && o_pad[SDM_PIN_PHA].oe_n &&
			o_pad[SDM_PIN_PHB].oe_n;
	endproperty
	a_unrouted: assert property (p_unrouted)
		else $error("reduced variant pad driven before configuration");

	property p_sclk_slave;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !unr_a && !i_gpio_sel[SDM_PIN_PHA] &&
			i_phase_a_alternate_select && !i_spi1_master |=>
			o_pad[SDM_PIN_PHA].oe_n &&
			o_spi1_serial_clock_in == $past(i_pad_in[SDM_PIN_PHA]);
	endproperty
	a_sclk_slave: assert property (p_sclk_slave)
		else $error("spi1 clock not received in slave mode");

	property p_tb0_route;
		@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_arst_n && i_ce && !unr_a && !i_gpio_sel[SDM_PIN_PHA] &&
			!i_phase_a_alternate_select && i_timer_sel[0] |=>
			o_timer_b_channel_zero_in == $past(i_pad_in[SDM_PIN_PHA]) &&
			o_decoder1_phase_a_input;
	endproperty
	a_tb0_route: assert property (p_tb0_route)
		else $error("timer b channel zero not routed");
endmodule

//--- test/sdm_periph_model.sv
// Purpose: on-chip spi1 and timer b drivers facing the pin mux
// Assumes: spi1 master clock idles low outside master frames
// Notes: timer drive patterns come from a free counter
`timescale 1ns/1ps
module sdm_periph_model (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_master,
	output logic o_sclk,
	output logic o_mosi,
	output sdm_pkg::sdm_drv_s o_tmr0,
	output sdm_pkg::sdm_drv_s o_tmr1
);
	import sdm_pkg::*;
	logic [4:0] cnt;
	assign o_tmr0 = '{out: cnt[0], oe: cnt[2]};
	assign o_tmr1 = '{out: cnt[1], oe: cnt[3]};
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt <= 5'h00;
			o_sclk <= 1'b0;
			o_mosi <= 1'b0;
		end else begin
			cnt <= cnt + 5'h01;
			o_sclk <= i_master & ~o_sclk;
			// data moves on the falling clock, half before latching
			if (i_master && o_sclk) begin
				o_mosi <= cnt[4] ^ cnt[1];
			end
		end
	end
endmodule

//--- test/sdm_pin_mux_tb.sv
// Purpose: self-checking bench for the shared-pin function mux
// Assumes: outputs follow sampled inputs by one enabled cycle
// Notes: random steps hold inputs two edges, then compare
`timescale 1ns/1ps
module sdm_pin_mux_tb;
	import sdm_pkg::*;
	logic clk, rst_n, ce, full, alt_a, alt_b, cfg, master, cfg_seen;
	logic [7:0] pe_pu, pc_pu;
	logic [2:0] gsel, gdir, gout, pad_in, gin;
	logic [1:0] tsel, unr;
	logic sclk, mosi, ss, pha, phb, sck_in, mosi_in, t0_in, t1_in;
	sdm_drv_s tmr0, tmr1, tmr0_s, tmr1_s;
	sdm_pad_s [2:0] pad, pad_save;
	logic sclk_s, mosi_s;
	logic [7:0] in_save;
	int failures = 0;
	int total_checks = 0;
	sdm_pin_mux dut_u (.i_sys_clk(clk), .i_arst_n(rst_n), .i_ce(ce),
		.i_variant_full(full), .i_port_e_pullup_enable(pe_pu),
		.i_port_c_pullup_enable(pc_pu), .i_phase_a_alternate_select(alt_a),
		.i_phase_b_alternate_select(alt_b), .i_gpio_sel(gsel),
		.i_gpio_dir(gdir), .i_gpio_out(gout), .i_timer_sel(tsel),
		.i_sw_cfg_done(cfg), .i_spi1_master(master),
		.i_spi1_serial_clock_out(sclk), .i_spi1_master_out_slave_in_out(mosi),
		.i_timer_b_channel_zero(tmr0), .i_timer_b_channel_one(tmr1),
		.i_pad_in(pad_in), .o_pad(pad), .o_spi0_slave_select(ss),
		.o_decoder1_phase_a_input(pha), .o_decoder1_phase_b_input(phb),
		.o_spi1_serial_clock_in(sck_in), .o_spi1_master_out_slave_in_in(mosi_in),
		.o_timer_b_channel_zero_in(t0_in), .o_timer_b_channel_one_in(t1_in),
		.o_gpio_in(gin), .o_unrouted(unr));
	sdm_periph_model peer_u (.i_sys_clk(clk), .i_arst_n(rst_n),
		.i_master(master), .o_sclk(sclk), .o_mosi(mosi), .o_tmr0(tmr0),
		.o_tmr1(tmr1));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_ph(input int i);
		logic u, g, a, ts, drv, o, pu, dec, tin;
		sdm_drv_s t;
		u = !full && !cfg_seen;
		g = gsel[i];
		a = (i == 1) ? alt_a : alt_b;
		ts = tsel[i-1];
		t = (i == 1) ? tmr0_s : tmr1_s;
		pu = (i == 1) ? pc_pu[0] : pc_pu[1];
		drv = 1'b0;
		o = 1'b0;
		if (u) begin
			drv = 1'b0;
		end else if (g) begin
			drv = gdir[i];
			o = gout[i];
		end else if (a) begin
			drv = master;
			o = (i == 1) ? sclk_s : mosi_s;
		end else if (ts) begin
			drv = t.oe;
			o = t.out;
		end
		dec = (!u && !g && !a && !ts) ? pad_in[i] : 1'b1;
		tin = (!u && !g && !a && ts) ? pad_in[i] : 1'b0;
		check("unrouted", 8'(unr[i-1]), 8'(u));
		check("oe_n", 8'(pad[i].oe_n), 8'(!drv));
		if (drv) check("out", 8'(pad[i].out), 8'(o));
		check("pu", 8'(pad[i].pu_en), 8'(pu & !drv));
		check("gpio_in", 8'(gin[i]), 8'(!u && g ? pad_in[i] : 1'b0));
		check("dec", 8'(i == 1 ? pha : phb), 8'(dec));
		if (!(ts && t.oe)) begin
			check("tmr_in", 8'(i == 1 ? t0_in : t1_in), 8'(tin));
		end
		check("spi_in", 8'(i == 1 ? sck_in : mosi_in),
			8'(!u && !g && a && !master ? pad_in[i] : 1'b0));
	endtask
	task automatic check_all;
		check("ss_oe", 8'(pad[0].oe_n), 8'(!(gsel[0] && gdir[0])));
		if (gsel[0] && gdir[0]) check("ss_out", 8'(pad[0].out), 8'(gout[0]));
		check("ss_pu", 8'(pad[0].pu_en),
			8'(pe_pu[7] & !(gsel[0] && gdir[0])));
		check("ss_in", 8'(ss), 8'(gsel[0] ? 1'b1 : pad_in[0]));
		check("ss_gin", 8'(gin[0]), 8'(gsel[0] ? pad_in[0] : 1'b0));
		chk_ph(1);
		chk_ph(2);
	endtask
	task automatic step(input logic rnd, input logic rcfg);
		@(posedge clk);
		if (rnd) begin
			gsel <= 3'($urandom & $urandom);
			gdir <= 3'($urandom);
			gout <= 3'($urandom);
			tsel <= 2'($urandom);
			alt_a <= 1'($urandom);
			alt_b <= 1'($urandom);
			master <= 1'($urandom);
			pad_in <= 3'($urandom);
			pe_pu <= 8'($urandom);
			pc_pu <= 8'($urandom);
			full <= 1'($urandom);
		end
		cfg <= rcfg;
		@(posedge clk);
		// peer drives as the design sampled them at this edge
		{tmr0_s, tmr1_s, sclk_s, mosi_s} = {tmr0, tmr1, sclk, mosi};
		@(negedge clk);
		if (ce) begin
			check_all();
		end
		// sticky mark takes effect from the next enabled edge
		if (cfg && ce) begin
			cfg_seen = 1'b1;
		end
	endtask
	initial begin
		total_checks = $urandom(32'h607B785C);
		total_checks = 0;
		{ce, full, alt_a, alt_b, cfg, master, cfg_seen} = 7'h60;
		{rst_n, pe_pu, pc_pu} = {1'b0, 8'hFF, 8'hFF};
		{gsel, gdir, gout, pad_in, tsel} = 14'h0000;
		repeat (8) @(posedge clk);
		check("rst_oe", 8'({pad[0].oe_n, pad[1].oe_n, pad[2].oe_n}),
			8'h07);
		check("rst_in", 8'({ss, pha, phb}), 8'h07);
		rst_n <= 1'b1;
		pad_in <= 3'h6;
		step(1'b0, 1'b0);
		@(posedge clk);
		pad_in <= 3'h1;
		step(1'b0, 1'b0);
		@(posedge clk);
		full <= 1'b0;
		repeat (3) step(1'b0, 1'b0);
		step(1'b0, 1'b1);
		step(1'b0, 1'b0);
		repeat (400) step(1'b1, 1'($urandom_range(0, 30) == 0));
		@(posedge clk);
		ce <= 1'b0;
		@(negedge clk);
		pad_save = pad;
		in_save = {ss, pha, phb, gin, unr};
		step(1'b1, 1'b0);
		check("freeze_ss", 8'(pad[0]), 8'(pad_save[0]));
		check("freeze_ph", 8'(pad[2:1]), 8'(pad_save[2:1]));
		check("freeze_in", 8'({ss, pha, phb, gin, unr}), in_save);
		@(posedge clk);
		ce <= 1'b1;
		step(1'b1, 1'b0);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		finish_test();
	end
endmodule
